/* File: dv/camera_csr_top_tb.sv */
// Self-checking bench for the camera register group: bus tasks and directed tests.
// Assumes the stream partner closes every transmission that it is handed.
`timescale 1ns/1ps
module camera_csr_top_tb;
    logic clk_in = 1'b0;
    logic resetn_in = 1'b0;
    logic [15:0] addr_in = 16'h0000;
    logic [31:0] wdata_in = 32'h0000_0000, rdata_out;
    logic wr_in = 1'b0, rd_in = 1'b0, stream_run_in = 1'b0, tx_done_in;
    logic trigger_mode_in = 1'b0, global_reset_in = 1'b1;
    logic format_change_in = 1'b0, oneshot_in = 1'b0, multishot_in = 1'b0, image_done_in = 1'b0;
    logic [11:0] capacity_in = 12'h007, shot_count_in = 12'h002, store_slot_out;
    camera_csr_pkg::expo_evt_t expo_in = '0;
    camera_csr_pkg::tx_cmd_t tx_cmd_out;
    logic store_out, retx_store_out, flash_commit_out, strobe_out, strobe_ref_out;
    int fail_count = 0, cmp_count = 0, n_commit = 0, n_ring = 0, n_tx = 0, n_retx = 0;
    int n_store = 0, n_resend = 0;
    logic [11:0] last_slot = 12'h000, tx_slot = 12'h000;

    always #5 clk_in = ~clk_in;

    camera_csr_top camera_csr_top_inst (.clk_in, .resetn_in, .addr_in, .wdata_in, .wr_in,
        .rd_in, .rdata_out, .stream_run_in, .trigger_mode_in, .global_reset_in,
        .format_change_in, .capacity_in, .oneshot_in, .multishot_in, .shot_count_in,
        .image_done_in, .tx_done_in, .expo_in, .tx_cmd_out, .store_out, .store_slot_out,
        .retx_store_out, .flash_commit_out, .strobe_out, .strobe_ref_out);
    stream_partner stream_partner_inst (.clk_in, .start_in(tx_cmd_out.start),
        .done_out(tx_done_in));

    // Pulses are tallied here so that tests can judge them after the fact.
    always @(posedge clk_in)
    begin
        n_commit <= n_commit + int'(flash_commit_out === 1'b1);
        n_tx <= n_tx + int'(tx_cmd_out.start === 1'b1);
        n_ring <= n_ring + int'(tx_cmd_out.start === 1'b1 && tx_cmd_out.from_ring === 1'b1);
        n_retx <= n_retx + int'(retx_store_out === 1'b1);
        n_store <= n_store + int'(store_out === 1'b1);
        n_resend <= n_resend + int'(tx_cmd_out.start === 1'b1 && tx_cmd_out.retx === 1'b1);
        if (store_out === 1'b1)
            last_slot <= store_slot_out;
        if (tx_cmd_out.start === 1'b1)
            tx_slot <= tx_cmd_out.slot;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            fail_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        @(posedge clk_in);
        wr_in <= 1'b1;
        addr_in <= a;
        wdata_in <= d;
        @(posedge clk_in);
        wr_in <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe, so they are taken just then.
    task automatic rd(input logic [15:0] a, input logic [31:0] exp);
        @(posedge clk_in);
        rd_in <= 1'b1;
        addr_in <= a;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1;
        chk(rdata_out, exp);
    endtask
    task automatic pls(input int k);
        @(posedge clk_in);
        case (k)
            0: image_done_in <= 1'b1;
            1: oneshot_in <= 1'b1;
            2: multishot_in <= 1'b1;
            3: format_change_in <= 1'b1;
            4: expo_in.first_start <= 1'b1;
            5: expo_in.last_start <= 1'b1;
            6: expo_in.first_end <= 1'b1;
            default: expo_in.last_end <= 1'b1;
        endcase
        @(posedge clk_in);
        {image_done_in, oneshot_in, multishot_in, format_change_in} <= 4'h0;
        expo_in <= '0;
        repeat (2) @(posedge clk_in);
    endtask
    task automatic give_verdict();
        $display("counts: %0d compares, %0d mismatches", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // The watchdog allows nearly fifty times the expected length of the tests.
    initial
    begin
        #100000;
        fail_count++;
        give_verdict();
    end

    initial
    begin
        repeat (6) @(posedge clk_in);
        resetn_in <= 1'b1;
        rd(16'h0634, 32'h0000_0400);
        rd(16'h1240, 32'h00b0_0841);
        rd(16'h1244, 32'h0000_0800);
        rd(16'h1104, 32'h0000_2000);
        rd(16'h0100, 32'h0000_0000);
        wr(16'h0634, 32'hffff_ffff);
        rd(16'h0634, 32'h0000_0403);
        repeat (5) pls(0);
        rd(16'h0634, 32'h0040_0403);
        chk(n_store, 5);
        chk(last_slot, 12'h000);
        $display("test registers and ring done");
        pls(1);
        repeat (20) @(posedge clk_in);
        chk(n_retx, 1);
        chk(n_resend, 1);
        pls(2);
        repeat (40) @(posedge clk_in);
        chk(n_ring, 2);
        chk(tx_slot, 12'h002);
        rd(16'h0634, 32'h0020_0403);
        @(posedge clk_in);
        stream_run_in <= 1'b1;
        pls(1);
        repeat (20) @(posedge clk_in);
        chk(n_tx, 3);
        stream_run_in <= 1'b0;
        chk(n_retx, 3);
        $display("test sends done");
        wr(16'h2000, 32'h1234_5678);
        rd(16'h1240, 32'h00b0_0801);
        rd(16'h2004, 32'hffff_ffff);
        rd(16'h2000, 32'h1234_5678);
        wr(16'h1240, 32'h0000_0000);
        chk(n_commit, 0);
        wr(16'h1240, 32'h0000_0040);
        repeat (2) @(posedge clk_in);
        chk(n_commit, 1);
        rd(16'h1240, 32'h00b0_0841);
        wr(16'h2008, 32'h0000_00a5);
        rd(16'h1244, 32'h0000_0800);
        repeat (2) @(posedge clk_in);
        chk(n_commit, 2);
        $display("test flash done");
        wr(16'h1104, 32'h0000_4001);
        rd(16'h1104, 32'h0000_6001);
        chk(strobe_ref_out, 1);
        pls(4);
        chk(strobe_out, 1);
        pls(7);
        chk(strobe_out, 0);
        wr(16'h1104, 32'h0000_c000);
        rd(16'h1104, 32'h0000_6000);
        wr(16'h1104, 32'h0000_8000);
        pls(4);
        chk(strobe_out, 0);
        pls(5);
        chk(strobe_out, 1);
        pls(6);
        chk(strobe_out, 0);
        $display("test strobe done");
        wr(16'h0634, 32'h0000_0003);
        rd(16'h0634, 32'h0000_0403);
        pls(0);
        pls(3);
        rd(16'h0634, 32'h0000_0703);
        $display("test reinit done");
        @(posedge clk_in);
        trigger_mode_in <= 1'b1;
        resetn_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        resetn_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        chk(strobe_ref_out, 1);
        rd(16'h0634, 32'h0000_0400);
        $display("test reset done");
        give_verdict();
    end
endmodule

/* File: dv/stream_partner.sv */
// Stream-side stand-in that ends each transmission a few cycles after its start.
// Assumes start is a one-cycle pulse on clk_in and only one send is open at a time.
`timescale 1ns/1ps
module stream_partner #(
    parameter int DLY = 3
) (
    input wire logic clk_in, // System clock.
    input wire logic start_in, // Transmission start pulse.
    output logic done_out // Transmission finished pulse.
);
    initial done_out = 1'b0;
    // A slow reply keeps the sequencer busy long enough to expose early starts.
    always @(posedge clk_in)
    begin
        done_out <= 1'b0;
        if (start_in === 1'b1)
        begin
            repeat (DLY) @(posedge clk_in);
            done_out <= 1'b1;
        end
    end
endmodule

/* File: inc/camera_csr_pkg.sv */
// Shared constants and carrier types for the camera buffer, flash and strobe registers.
// Assumes one 100 MHz clock and a byte-addressed register port of 32-bit words.
package camera_csr_pkg;
    // Register byte offsets; the flash window is one 256-byte block.
    localparam logic [15:0] OFS_IMG_BUF = 16'h0634;
    localparam logic [15:0] OFS_STROBE = 16'h1104;
    localparam logic [15:0] OFS_FLASH_CTRL = 16'h1240;
    localparam logic [15:0] OFS_FLASH_OFS = 16'h1244;
    localparam logic [15:0] OFS_WIN_BASE = 16'h2000;
    localparam int WIN_AW = 6;
    // Field positions.
    localparam int IB_EN_BIT = 0;
    localparam int IB_PATH_BIT = 1;
    localparam int IB_CAP_LSB = 8;
    localparam int IB_CNT_LSB = 20;
    localparam int FC_PRES_BIT = 0;
    localparam int FC_CLEAN_BIT = 6;
    localparam int FC_PSZ_LSB = 8;
    localparam int FC_NPG_LSB = 20;
    localparam int ST_REF_BIT = 0;
    localparam int ST_SHUT_BIT = 13;
    localparam int ST_EXP_LSB = 14;
    localparam int CNT_W = 12;
    // Reset and constant field values.
    localparam logic [11:0] DEF_CAPACITY = 12'h004;
    localparam logic [11:0] PAGE_SIZE_CODE = 12'h008;
    localparam logic [11:0] NUM_PAGES_CODE = 12'h00b;
    localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

    typedef enum logic [1:0] {
        EXP_LINE1 = 2'b00,
        EXP_ANY = 2'b01,
        EXP_ALL = 2'b10,
        EXP_BAD = 2'b11
    } expo_mode_t;

    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b00,
        SEQ_SEND = 2'b01,
        SEQ_WAIT = 2'b11
    } seq_state_t;

    // Exposure timing events from the sensor timing logic, one-cycle pulses.
    typedef struct packed {
        logic first_start;
        logic first_end;
        logic last_start;
        logic last_end;
    } expo_evt_t;

    // Transmit request towards the streaming path.
    typedef struct packed {
        logic start;
        logic from_ring;
        logic retx;
        logic [11:0] slot;
    } tx_cmd_t;
endpackage

/* File: logic/camera_csr_top.sv */
// Register group for the image buffer, data-flash page and strobe timing of a camera.
// Assumes all control and event inputs come from logic on clk_in, not from pins.
//
// Local design decision: the strobed register port.
`timescale 1ns/1ps
module camera_csr_top #(
    parameter logic FLASH_PRESENT = 1'b1,
    parameter logic [11:0] RESET_CAPACITY = camera_csr_pkg::DEF_CAPACITY
) (
    input wire logic clk_in, // 100 MHz system clock.
    input wire logic resetn_in, // Asynchronous reset, active low.
    input wire logic [15:0] addr_in, // Register byte address.
    input wire logic [31:0] wdata_in, // Register write data.
    input wire logic wr_in, // Write strobe.
    input wire logic rd_in, // Read strobe.
    output logic [31:0] rdata_out, // Read data, cycle after the strobe.
    input wire logic stream_run_in, // Continuous acquisition running.
    input wire logic trigger_mode_in, // Triggered mode selected.
    input wire logic global_reset_in, // Sensor in global reset shutter.
    input wire logic format_change_in, // Format, mode, size or coding changed.
    input wire logic [11:0] capacity_in, // Images that fit in the new format.
    input wire logic oneshot_in, // One-shot command pulse.
    input wire logic multishot_in, // Multi-shot command pulse.
    input wire logic [11:0] shot_count_in, // Multi-shot image count.
    input wire logic image_done_in, // Acquired image complete.
    input wire logic tx_done_in, // Any image transmission finished.
    input wire camera_csr_pkg::expo_evt_t expo_in, // Exposure timing events.
    output camera_csr_pkg::tx_cmd_t tx_cmd_out, // Transmit request.
    output logic store_out, // Store acquired image pulse.
    output logic [11:0] store_slot_out, // Ring slot for that image.
    output logic retx_store_out, // Copy sent image to retransmit buffer.
    output logic flash_commit_out, // Program staged page into flash.
    output logic strobe_out, // Strobe exposure window.
    output logic strobe_ref_out // Strobe timed from trigger when high.
);
    localparam int AW = camera_csr_pkg::WIN_AW;
    localparam logic [31:0] FLASH_OFS_WORD = {18'h00000, camera_csr_pkg::OFS_WIN_BASE[15:2]};

    camera_csr_pkg::seq_state_t st_reg, st_next;
    camera_csr_pkg::expo_mode_t expo_mode_reg;
    camera_csr_pkg::tx_cmd_t tx_cmd_reg;
    logic buf_en_reg, path_reg, dirty_reg, commit_reg, strobe_reg, ref_reg, init_done_reg;
    logic from_ring_reg, store_reg, retx_reg, win_rd_reg;
    logic [11:0] cap_reg, rem_reg, store_slot_reg;
    logic [31:0] csr_rdata_reg;
    logic [31:0] mem_q;
    logic [11:0] ring_count, ring_wr_slot, ring_rd_slot;

    // Address decode.
    wire sel_ib = (addr_in == camera_csr_pkg::OFS_IMG_BUF);
    wire sel_st = (addr_in == camera_csr_pkg::OFS_STROBE);
    wire sel_fc = (addr_in == camera_csr_pkg::OFS_FLASH_CTRL);
    wire sel_fo = (addr_in == camera_csr_pkg::OFS_FLASH_OFS);
    wire sel_win = (addr_in[15:8] == camera_csr_pkg::OFS_WIN_BASE[15:8]);
    wire acc = wr_in || rd_in;
    wire wr_ib = wr_in && sel_ib;
    wire wr_st = wr_in && sel_st;
    wire win_wr = wr_in && sel_win;
    wire win_rd = rd_in && sel_win;

    // Flash commit: an explicit clean request, or any touch of another control register.
    wire other_ctl = acc && (sel_ib || sel_st || sel_fo);
    wire clean_req = wr_in && sel_fc && wdata_in[camera_csr_pkg::FC_CLEAN_BIT];
    wire commit = dirty_reg && (clean_req || other_ctl);

    // Buffer control; the path bit is forced to live while the stream runs.
    wire buffered = path_reg && !stream_run_in;
    wire ring_init = (wr_ib && wdata_in[camera_csr_pkg::IB_EN_BIT]) || format_change_in;
    wire ring_push = buf_en_reg && image_done_in;
    wire ring_pop = (st_reg == camera_csr_pkg::SEQ_SEND) && from_ring_reg;
    wire go_one = (st_reg == camera_csr_pkg::SEQ_IDLE) && oneshot_in && buffered;
    wire go_multi = (st_reg == camera_csr_pkg::SEQ_IDLE) && multishot_in && buffered
        && !oneshot_in && (ring_count != '0);
    wire [11:0] shots = (shot_count_in == '0) ? 12'h001 : shot_count_in;
    wire more = from_ring_reg && (rem_reg > 12'h001) && (ring_count != '0);
    wire [1:0] exp_field = wdata_in[camera_csr_pkg::ST_EXP_LSB +: 2];

    // Register read values; reserved positions are zero.
    wire [31:0] ib_word = {ring_count, cap_reg, 6'h00, path_reg, buf_en_reg};
    wire [31:0] st_word = {16'h0000, expo_mode_reg, global_reset_in, 12'h000, ref_reg};
    wire [31:0] fc_word = {camera_csr_pkg::NUM_PAGES_CODE, camera_csr_pkg::PAGE_SIZE_CODE,
        1'b0, !dirty_reg, 5'h00, FLASH_PRESENT};
    wire [31:0] csr_mux = sel_ib ? ib_word :
        sel_st ? st_word :
        sel_fc ? fc_word :
        sel_fo ? FLASH_OFS_WORD : camera_csr_pkg::ZERO_WORD;

    img_ring #(.CW(camera_csr_pkg::CNT_W)) u_ring (
        .clk_in(clk_in),
        .resetn_in(resetn_in),
        .init_in(ring_init),
        .push_in(ring_push),
        .pop_in(ring_pop),
        .cap_in(cap_reg),
        .count_out(ring_count),
        .wr_slot_out(ring_wr_slot),
        .rd_slot_out(ring_rd_slot)
    );

    flash_page_mem #(.AW(AW), .DW(32)) u_page (
        .clk_in(clk_in),
        .resetn_in(resetn_in),
        .wr_in(win_wr),
        .rd_in(win_rd),
        .addr_in(addr_in[AW+1:2]),
        .wdata_in(wdata_in),
        .rdata_out(mem_q)
    );

    // Writable control fields; the invalid exposure code is refused and the old value kept.
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            buf_en_reg <= 1'b0;
            path_reg <= 1'b0;
            expo_mode_reg <= camera_csr_pkg::EXP_LINE1;
        end
        else
        begin
            if (wr_ib)
            begin
                buf_en_reg <= wdata_in[camera_csr_pkg::IB_EN_BIT];
                path_reg <= wdata_in[camera_csr_pkg::IB_PATH_BIT];
            end
            if (wr_st && exp_field != camera_csr_pkg::EXP_BAD)
                expo_mode_reg <= camera_csr_pkg::expo_mode_t'(exp_field);
        end
    end

    // Strobe reference takes the mode default once after reset, then follows writes.
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            init_done_reg <= 1'b0;
            ref_reg <= 1'b0;
        end
        else
        begin
            init_done_reg <= 1'b1;
            if (!init_done_reg)
                ref_reg <= trigger_mode_in;
            else if (wr_st)
                ref_reg <= wdata_in[camera_csr_pkg::ST_REF_BIT];
        end
    end

    // Capacity is never allowed to read as zero.
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            cap_reg <= RESET_CAPACITY;
        else if (format_change_in)
            cap_reg <= (capacity_in == '0) ? 12'h001 : capacity_in;
    end

    // Page dirty flag: a window write in the commit cycle keeps the page dirty.
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            dirty_reg <= 1'b0;
            commit_reg <= 1'b0;
        end
        else
        begin
            dirty_reg <= win_wr || (dirty_reg && !commit);
            commit_reg <= commit;
        end
    end

    // Send sequencer next state.
    always_comb
    begin
        st_next = st_reg;
        case (st_reg)
            camera_csr_pkg::SEQ_IDLE:
                if (go_one || go_multi)
                    st_next = camera_csr_pkg::SEQ_SEND;
            camera_csr_pkg::SEQ_SEND:
                st_next = camera_csr_pkg::SEQ_WAIT;
            camera_csr_pkg::SEQ_WAIT:
                if (tx_done_in)
                    st_next = more ? camera_csr_pkg::SEQ_SEND : camera_csr_pkg::SEQ_IDLE;
            default:
                st_next = camera_csr_pkg::SEQ_IDLE;
        endcase
    end

    // Sequencer registers; a one-shot in the buffered path sends, whether or not an image exists.
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            st_reg <= camera_csr_pkg::SEQ_IDLE;
            from_ring_reg <= 1'b0;
            rem_reg <= '0;
        end
        else
        begin
            st_reg <= st_next;
            if (go_one)
            begin
                from_ring_reg <= 1'b0;
                rem_reg <= 12'h001;
            end
            else if (go_multi)
            begin
                from_ring_reg <= 1'b1;
                rem_reg <= shots;
            end
            else if (st_reg == camera_csr_pkg::SEQ_WAIT && tx_done_in)
                rem_reg <= rem_reg - 12'h001;
        end
    end

    // Transmit request pulse, issued one cycle after the sequencer enters its send state.
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            tx_cmd_reg <= '0;
        else
        begin
            tx_cmd_reg.start <= (st_reg == camera_csr_pkg::SEQ_SEND);
            tx_cmd_reg.from_ring <= from_ring_reg;
            tx_cmd_reg.retx <= !from_ring_reg;
            tx_cmd_reg.slot <= from_ring_reg ? ring_rd_slot : 12'h000;
        end
    end

    // Image store and retransmit copy pulses.
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            store_reg <= 1'b0;
            store_slot_reg <= '0;
            retx_reg <= 1'b0;
        end
        else
        begin
            store_reg <= ring_push;
            store_slot_reg <= ring_wr_slot;
            retx_reg <= tx_done_in;
        end
    end

    // Strobe window; a start and an end in one cycle leave the strobe on.
    logic win_set, win_clr;
    always_comb
    begin
        win_set = expo_in.first_start;
        win_clr = expo_in.first_end;
        case (expo_mode_reg)
            camera_csr_pkg::EXP_ANY:
                if (global_reset_in)
                    win_clr = expo_in.last_end;
            camera_csr_pkg::EXP_ALL:
                if (global_reset_in)
                    win_set = expo_in.last_start;
            camera_csr_pkg::EXP_LINE1:
                win_set = expo_in.first_start;
            default:
                win_set = 1'b0;
        endcase
    end

    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            strobe_reg <= 1'b0;
        else
            strobe_reg <= win_set || (strobe_reg && !win_clr);
    end

    // Read data stands only in the cycle after the read strobe.
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            csr_rdata_reg <= '0;
            win_rd_reg <= 1'b0;
        end
        else
        begin
            csr_rdata_reg <= (rd_in && !sel_win) ? csr_mux : camera_csr_pkg::ZERO_WORD;
            win_rd_reg <= win_rd;
        end
    end

    // Both sources are registers; the window word is only selected after a window read.
    assign rdata_out = win_rd_reg ? mem_q : csr_rdata_reg;
    assign tx_cmd_out = tx_cmd_reg;
    assign store_out = store_reg;
    assign store_slot_out = store_slot_reg;
    assign retx_store_out = retx_reg;
    assign flash_commit_out = commit_reg;
    assign strobe_out = strobe_reg;
    assign strobe_ref_out = ref_reg;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!resetn_in);

    property p_run_blocks;
        (stream_run_in && st_reg == camera_csr_pkg::SEQ_IDLE) |=> st_reg == camera_csr_pkg::SEQ_IDLE;
    endproperty
    a_run_blocks: assert property (p_run_blocks) else $error("Buffered send while running.");
    property p_multi_send;
        go_multi |-> ##2 (tx_cmd_out.start && tx_cmd_out.from_ring);
    endproperty
    a_multi_send: assert property (p_multi_send) else $error("Multi-shot did not send.");
    property p_one_send;
        go_one |-> ##2 (tx_cmd_out.start && tx_cmd_out.retx);
    endproperty
    a_one_send: assert property (p_one_send) else $error("One-shot did not resend.");
    property p_store;
        ring_push |=> (store_out && store_slot_out == $past(ring_wr_slot));
    endproperty
    a_store: assert property (p_store) else $error("Acquired image not stored.");
    property p_overwrite;
        (ring_push && !ring_init && !ring_pop && ring_count == cap_reg) |=> $stable(ring_count);
    endproperty
    a_overwrite: assert property (p_overwrite) else $error("Full ring count moved.");
    property p_retx;
        tx_done_in |=> retx_store_out;
    endproperty
    a_retx: assert property (p_retx) else $error("Sent image not kept.");
    property p_reinit;
        (wr_ib && wdata_in[0]) |=> (ring_count == '0);
    endproperty
    a_reinit: assert property (p_reinit) else $error("Buffer not reinitialised.");
    property p_cap_nonzero;
        cap_reg != '0;
    endproperty
    a_cap_nonzero: assert property (p_cap_nonzero) else $error("Capacity reads zero.");
    property p_count_read;
        (rd_in && sel_ib) |=> (rdata_out[31:20] == $past(ring_count));
    endproperty
    a_count_read: assert property (p_count_read) else $error("Count field wrong.");
    property p_commit;
        (dirty_reg && clean_req && !win_wr) |=> (flash_commit_out && !dirty_reg);
    endproperty
    a_commit: assert property (p_commit) else $error("Clean write did not commit.");
    property p_any_pixel;
        (expo_mode_reg == camera_csr_pkg::EXP_ANY && global_reset_in && expo_in.first_start)
            |=> strobe_out;
    endproperty
    a_any_pixel: assert property (p_any_pixel) else $error("Any-pixel strobe late.");

    c_multi: cover property (go_multi ##[1:50] (st_reg == camera_csr_pkg::SEQ_IDLE));
    c_full_push: cover property (ring_push && ring_count == cap_reg);
    c_other_commit: cover property (dirty_reg && other_ctl);
endmodule

/* File: logic/flash_page_mem.sv */
// Staging memory for the data-flash page, reached through the flash data window.
// Assumes single-cycle write and read strobes on the caller's clock.
`timescale 1ns/1ps
module flash_page_mem #(
    parameter int AW = 6,
    parameter int DW = 32
) (
    input wire logic clk_in, // System clock.
    input wire logic resetn_in, // Asynchronous reset, active low.
    input wire logic wr_in, // Write strobe.
    input wire logic rd_in, // Read strobe.
    input wire logic [AW-1:0] addr_in, // Word address.
    input wire logic [DW-1:0] wdata_in, // Write data.
    output logic [DW-1:0] rdata_out // Registered read data.
);
    logic [DW-1:0] mem [2**AW];
    logic [2**AW-1:0] written_reg;
    logic [DW-1:0] rdata_reg;

    // Array storage needs no reset; the written flags make fresh words read as ones.
    always_ff @(posedge clk_in)
    begin
        if (wr_in)
            mem[addr_in] <= wdata_in;
    end

    // Flags and read register.
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            written_reg <= '0;
            rdata_reg <= '1;
        end
        else
        begin
            if (wr_in)
                written_reg[addr_in] <= 1'b1;
            if (rd_in)
                rdata_reg <= written_reg[addr_in] ? mem[addr_in] : '1;
        end
    end

    assign rdata_out = rdata_reg;

    property p_fresh_ones;
        @(posedge clk_in) disable iff (!resetn_in)
        (rd_in && !written_reg[addr_in]) |=> (rdata_out == '1);
    endproperty
    a_fresh_ones: assert property (p_fresh_ones) else $error("Unwritten word not all ones.");
endmodule

/* File: logic/img_ring.sv */
// Slot bookkeeping for the circular image buffer: next write slot, oldest slot and count.
// Assumes the capacity input is never zero and only changes together with init.
`timescale 1ns/1ps
module img_ring #(
    parameter int CW = 12
) (
    input wire logic clk_in, // System clock.
    input wire logic resetn_in, // Asynchronous reset, active low.
    input wire logic init_in, // Discard all stored images.
    input wire logic push_in, // Store a new image.
    input wire logic pop_in, // Release the oldest image.
    input wire logic [CW-1:0] cap_in, // Slot capacity.
    output logic [CW-1:0] count_out, // Images held.
    output logic [CW-1:0] wr_slot_out, // Slot the next image goes to.
    output logic [CW-1:0] rd_slot_out // Oldest image slot.
);
    logic [CW-1:0] head_reg, tail_reg, count_reg;
    logic full, do_pop, adv_tail;

    function automatic logic [CW-1:0] wrap_inc(input logic [CW-1:0] v, input logic [CW-1:0] cap);
        wrap_inc = (v + 1'b1 == cap) ? '0 : v + 1'b1;
    endfunction

    // A push into a full ring drops the oldest image, so the tail moves with the head.
    assign full = (count_reg == cap_in);
    assign do_pop = pop_in && (count_reg != '0);
    assign adv_tail = do_pop || (push_in && full);

    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            head_reg <= '0;
            tail_reg <= '0;
            count_reg <= '0;
        end
        else if (init_in)
        begin
            head_reg <= '0;
            tail_reg <= '0;
            count_reg <= '0;
        end
        else
        begin
            if (push_in)
                head_reg <= wrap_inc(head_reg, cap_in);
            if (adv_tail)
                tail_reg <= wrap_inc(tail_reg, cap_in);
            if (push_in && !full && !do_pop)
                count_reg <= count_reg + 1'b1;
            else if (do_pop && !push_in)
                count_reg <= count_reg - 1'b1;
        end
    end

    assign count_out = count_reg;
    assign wr_slot_out = head_reg;
    assign rd_slot_out = tail_reg;
endmodule
